// >>> inc/ufic_pkg.sv
/*
 Constants for the frame index / configure flag / port register block.
 Assumes a 50 MHz controller clock and the documented register port.
*/
package ufic_pkg;
   localparam int CLK_MHZ = 50;
   localparam int MICROFRAME_US = 125;
   localparam int MICROFRAME_CYC = MICROFRAME_US * CLK_MHZ;
   localparam logic [7:0] MICROFRAME_INDEX_OFS = 8'h2c;
   localparam logic [7:0] CONFIGURE_FLAG_REG_OFS = 8'h60;
   localparam logic [7:0] HOST_COMMAND_REG_OFS = 8'h20;
   localparam logic [7:0] HOST_STATUS_REG_OFS = 8'h24;
   localparam logic [7:0] PORT_STATE_CTRL_REG_OFS = 8'h64;
   localparam int INDEX_W = 14;
   localparam logic [13:0] INDEX_RST = 14'h0000;
   localparam int RUN_STOP_POS = 0;
   localparam int HC_RESET_POS = 1;
   localparam int LIST_SIZE_POS = 2;
   localparam int LIST_WRAP_POS = 3;
   localparam int CONFIGURED_POS = 0;
   localparam int PORT_ENABLE_POS = 2;
   localparam int PORT_CONNECT_POS = 0;
   localparam int PORT_POWER_POS = 12;
   localparam int PORT_OWNER_POS = 13;
   localparam int LIST_BASE_BIT = 3;
endpackage

// >>> rtl/ufic_uframe_timer.sv
/*
 Microframe tick generator.
 Assumes a synchronous clock enable and a run level from the register file.
*/
`timescale 1ns/1ns
module ufic_uframe_timer
(
   input wire logic clk,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic run,
   output logic tick
);
   typedef struct packed
   {
      logic [12:0] cnt;
      logic tick;
   } ufic_tmr_t;

   ufic_tmr_t s_q;
   ufic_tmr_t s_d;

   always_comb
   begin
      s_d = s_q;
      s_d.tick = 1'b0;
      // Counter restarts when stopped so the first period is full length
      if (!run)
      begin
         s_d.cnt = '0;
      end
      else if (s_q.cnt == 13'(ufic_pkg::MICROFRAME_CYC - 1))
      begin
         s_d.cnt = '0;
         s_d.tick = 1'b1;
      end
      else
      begin
         s_d.cnt = s_q.cnt + 13'h0001;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_q <= '0;
      end
      else if (clkEn)
      begin
         s_q <= s_d;
      end
   end

   assign tick = s_q.tick;

   property p_tick_period;
      @(posedge clk) disable iff (rst)
      s_q.tick && clkEn |=> !s_q.tick;
   endproperty
   a_tick_period: assert property (p_tick_period)
      else $error("tick lasted over one cycle");
endmodule

// >>> rtl/ufic_regs.sv
/*
 Frame index, configure flag, and port state register logic of a host
 controller, with run/stop, list size and wrap status bits.
 Assumes a synchronous register port (address, write, read strobes) on clk;
 hcReset is a synchronous host controller reset pulse from elsewhere.
*/
`timescale 1ns/1ns
module ufic_regs
(
   input wire logic clk,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic hcReset,
   input wire logic [7:0] regAddr,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [31:0] regWdata,
   input wire logic portConnect,
   output logic [31:0] regRdata,
   output logic [13:0] sofFrameNumber,
   output logic [9:0] listEntry,
   output logic runStopBit,
   output logic configuredFlag,
   output logic portOwnershipBit,
   output logic portPowerBit,
   output logic listWrapFlag
);
   typedef struct packed
   {
      logic [13:0] index;
      logic runStop;
      logic [1:0] listSize;
      logic listWrap;
      logic configured;
      logic owner;
      logic power;
      logic enabled;
      logic connect;
      logic [9:0] entry;
      logic [31:0] rdata;
   } ufic_state_t;

   ufic_state_t s_q;
   ufic_state_t s_d;
   logic tick;
   logic wr;
   logic [13:0] nextIndex;
   logic [3:0] topBit;
   logic wrapNow;

   ufic_uframe_timer u_timer
   (
      .clk(clk),
      .rst(rst),
      .clkEn(clkEn),
      .run(s_q.runStop),
      .tick(tick)
   );

   assign wr = regWrite;
   assign nextIndex = s_q.index + 14'h0001;
   // Size 0..2 gives 1024/512/256 entries; top bit 12/11/10
   assign topBit = 4'hc - {2'h0, s_q.listSize};
   // Wrap when bits top..0 all ones and a tick lands
   always_comb
   begin
      wrapNow = 1'b1;
      for (int i = ufic_pkg::LIST_BASE_BIT; i <= 12; i++)
      begin
         if (i <= int'(topBit) && !s_q.index[i])
         begin
            wrapNow = 1'b0;
         end
      end
      if (s_q.index[2:0] != 3'h7)
      begin
         wrapNow = 1'b0;
      end
   end

   always_comb
   begin
      s_d = s_q;
      // Index steps only on ticks that land while run/stop is set
      if (tick && s_q.runStop)
      begin
         s_d.index = nextIndex;
         if (wrapNow)
         begin
            s_d.listWrap = 1'b1;
         end
      end
      if (wr)
      begin
         unique case (regAddr)
            ufic_pkg::MICROFRAME_INDEX_OFS:
            begin
               s_d.index = regWdata[13:0];
            end
            ufic_pkg::HOST_COMMAND_REG_OFS:
            begin
               s_d.runStop = regWdata[ufic_pkg::RUN_STOP_POS];
               s_d.listSize = regWdata[ufic_pkg::LIST_SIZE_POS +: 2];
            end
            ufic_pkg::HOST_STATUS_REG_OFS:
            begin
               // Set wins over a same-cycle clear
               if (regWdata[ufic_pkg::LIST_WRAP_POS]
                   && !(tick && s_q.runStop && wrapNow))
               begin
                  s_d.listWrap = 1'b0;
               end
            end
            ufic_pkg::CONFIGURE_FLAG_REG_OFS:
            begin
               s_d.configured = regWdata[ufic_pkg::CONFIGURED_POS];
            end
            ufic_pkg::PORT_STATE_CTRL_REG_OFS:
            begin
               s_d.power = regWdata[ufic_pkg::PORT_POWER_POS];
               // Unpowered port ignores state changes
               if (s_q.power)
               begin
                  s_d.enabled = regWdata[ufic_pkg::PORT_ENABLE_POS];
                  s_d.owner = regWdata[ufic_pkg::PORT_OWNER_POS];
               end
            end
            default:
            begin
            end
         endcase
      end
      s_d.connect = s_q.power && portConnect;
      if (!s_d.connect)
      begin
         s_d.enabled = 1'b0;
      end
      if (!s_q.configured && s_d.configured)
      begin
         s_d.owner = 1'b0;
      end
      if (!s_d.configured)
      begin
         s_d.owner = 1'b1;
      end
      s_d.entry = s_d.index[12:3];
      unique case (s_d.listSize)
         2'h1: s_d.entry[9] = 1'b0;
         2'h2: s_d.entry[9:8] = 2'h0;
         default: ;
      endcase
      s_d.rdata = '0;
      if (regRead)
      begin
         unique case (regAddr)
            ufic_pkg::MICROFRAME_INDEX_OFS:
               s_d.rdata[13:0] = s_q.index;
            ufic_pkg::HOST_COMMAND_REG_OFS:
            begin
               s_d.rdata[ufic_pkg::RUN_STOP_POS] = s_q.runStop;
               s_d.rdata[ufic_pkg::LIST_SIZE_POS +: 2] = s_q.listSize;
            end
            ufic_pkg::HOST_STATUS_REG_OFS:
               s_d.rdata[ufic_pkg::LIST_WRAP_POS] = s_q.listWrap;
            ufic_pkg::CONFIGURE_FLAG_REG_OFS:
               s_d.rdata[ufic_pkg::CONFIGURED_POS] = s_q.configured;
            ufic_pkg::PORT_STATE_CTRL_REG_OFS:
            begin
               s_d.rdata[ufic_pkg::PORT_OWNER_POS] = s_q.owner;
               s_d.rdata[ufic_pkg::PORT_POWER_POS] = s_q.power;
               s_d.rdata[ufic_pkg::PORT_ENABLE_POS] = s_q.enabled;
               s_d.rdata[ufic_pkg::PORT_CONNECT_POS] = s_q.connect;
            end
            default:
            begin
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_q <= '0;
         s_q.owner <= 1'b1;
      end
      else if (clkEn)
      begin
         if (hcReset)
         begin
            s_q <= '0;
            s_q.owner <= 1'b1;
         end
         else
         begin
            s_q <= s_d;
         end
      end
   end

   assign regRdata = s_q.rdata;
   assign sofFrameNumber = s_q.index;
   assign listEntry = s_q.entry;
   assign runStopBit = s_q.runStop;
   assign configuredFlag = s_q.configured;
   assign portOwnershipBit = s_q.owner;
   assign portPowerBit = s_q.power;
   assign listWrapFlag = s_q.listWrap;

   property p_stopped_hold;
      @(posedge clk) disable iff (rst)
      clkEn && !s_q.runStop && !wr && !hcReset
      |=> $stable(s_q.index);
   endproperty
   a_stopped_hold: assert property (p_stopped_hold)
      else $error("index moved while stopped");

   property p_tick_inc;
      @(posedge clk) disable iff (rst)
      clkEn && tick && s_q.runStop && !wr && !hcReset
      |=> s_q.index == $past(s_q.index) + 14'h0001;
   endproperty
   a_tick_inc: assert property (p_tick_inc)
      else $error("index missed microframe increment");

   property p_wrap_zero;
      @(posedge clk) disable iff (rst)
      clkEn && tick && s_q.runStop && s_q.index == 14'h3fff
      && !wr && !hcReset |=> s_q.index == 14'h0000;
   endproperty
   a_wrap_zero: assert property (p_wrap_zero)
      else $error("index did not wrap to zero");

   property p_write_sof;
      @(posedge clk) disable iff (rst)
      clkEn && wr && regAddr == ufic_pkg::MICROFRAME_INDEX_OFS && !hcReset
      |=> sofFrameNumber == $past(regWdata[13:0]);
   endproperty
   a_write_sof: assert property (p_write_sof)
      else $error("index write not reflected in frame number");

   property p_owner_unconf;
      @(posedge clk) disable iff (rst)
      !s_q.configured |-> s_q.owner;
   endproperty
   a_owner_unconf: assert property (p_owner_unconf)
      else $error("owner low while unconfigured");

   property p_owner_rise;
      @(posedge clk) disable iff (rst)
      $rose(s_q.configured) |-> !s_q.owner;
   endproperty
   a_owner_rise: assert property (p_owner_rise)
      else $error("owner not cleared on configure");

   property p_wrap_flag;
      @(posedge clk) disable iff (rst)
      clkEn && tick && s_q.runStop && wrapNow && !hcReset
      |=> s_q.listWrap;
   endproperty
   a_wrap_flag: assert property (p_wrap_flag)
      else $error("wrap flag not set on rollover");

   property p_hc_reset;
      @(posedge clk) disable iff (rst)
      clkEn && hcReset |=> !s_q.enabled && !s_q.connect && !s_q.power;
   endproperty
   a_hc_reset: assert property (p_hc_reset)
      else $error("port not idle after controller reset");

   property p_unpowered;
      @(posedge clk) disable iff (rst)
      !s_q.power |=> !s_q.enabled;
   endproperty
   a_unpowered: assert property (p_unpowered)
      else $error("port enabled without power");
endmodule

// >>> test/usb_host_frame_index_config_bench.sv
/*
 Self-checking bench for the frame index / configure flag / port block.
 Assumes ufic_regs is the top design module and ufic_pkg is compiled first.
*/
`timescale 1ns/1ns
module usb_host_frame_index_config_bench;
   logic clk, rst, clkEn, hcReset, regWrite, regRead, portConnect;
   logic [7:0] regAddr;
   logic [31:0] regWdata, regRdata;
   logic [13:0] sofFrameNumber;
   logic [9:0] listEntry;
   logic runStopBit, configuredFlag, portOwnershipBit, portPowerBit;
   logic listWrapFlag;
   int badCount, totalChecks, cycles, seed, n, k;
   int mIdx, mSize, mRun, mCf, mOwn, mPow, mEn;

   ufic_regs uut (.clk(clk), .rst(rst), .clkEn(clkEn), .hcReset(hcReset),
      .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
      .regWdata(regWdata), .portConnect(portConnect), .regRdata(regRdata),
      .sofFrameNumber(sofFrameNumber), .listEntry(listEntry),
      .runStopBit(runStopBit), .configuredFlag(configuredFlag),
      .portOwnershipBit(portOwnershipBit), .portPowerBit(portPowerBit),
      .listWrapFlag(listWrapFlag));

   initial
   begin
      clk = 0;
      forever #10 clk = ~clk;
   end

   task automatic endSim;
      $display("Checks %0d, mismatches %0d", totalChecks, badCount);
      if (badCount == 0 && totalChecks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Hang guard; the full sequence needs roughly 32200 cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         badCount++;
         $display("BAD timeout expected end seen hang");
         endSim();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      totalChecks++;
      if (got !== exp)
      begin
         badCount++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(negedge clk);
      regAddr = a;
      regWdata = d;
      regWrite = 1'b1;
      @(negedge clk);
      regWrite = 1'b0;
   endtask

   task automatic rdChk(input string what, input logic [7:0] a,
                        input logic [31:0] exp);
      @(negedge clk);
      regAddr = a;
      regRead = 1'b1;
      @(negedge clk);
      regRead = 1'b0;
      chk(what, exp, regRdata);
   endtask

   // Waits for the index to move; bounded a little past one microframe
   task automatic waitTick(output int cnt);
      logic [13:0] s;
      s = sofFrameNumber;
      cnt = 0;
      while (sofFrameNumber === s && cnt < 7000)
      begin
         @(negedge clk);
         cnt++;
      end
      if (cnt >= 7000)
      begin
         badCount++;
         $display("BAD tick expected index change seen none");
         endSim();
      end
   endtask

   task automatic chkAll;
      int ent;
      ent = (mIdx >> 3) & ((1 << (10 - mSize)) - 1);
      chk("index", 32'(mIdx), {18'h0, sofFrameNumber});
      chk("entry", 32'(ent), {22'h0, listEntry});
      chk("run", 32'(mRun), {31'h0, runStopBit});
      chk("cfg", 32'(mCf), {31'h0, configuredFlag});
      chk("owner", 32'(mOwn), {31'h0, portOwnershipBit});
      chk("power", 32'(mPow), {31'h0, portPowerBit});
      rdChk("indexReg", ufic_pkg::MICROFRAME_INDEX_OFS, 32'(mIdx));
      rdChk("cfgReg", ufic_pkg::CONFIGURE_FLAG_REG_OFS, 32'(mCf));
      rdChk("portReg", ufic_pkg::PORT_STATE_CTRL_REG_OFS,
            32'((mOwn << 13) | (mPow << 12) | (mEn << 2)
            | (mPow & int'(portConnect))));
   endtask

   initial
   begin
      seed = 32'h7e0a;
      rst = 1'b1;
      clkEn = 1'b1;
      hcReset = 1'b0;
      regWrite = 1'b0;
      regRead = 1'b0;
      regAddr = 8'h00;
      regWdata = 32'h0;
      portConnect = 1'($random(seed));
      repeat (6) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      mIdx = 0; mSize = 0; mRun = 0; mCf = 0; mOwn = 1; mPow = 0; mEn = 0;
      chkAll();
      rdChk("unmapped", 8'h40, 32'h0);
      // Index writes under list sizes 0, 1 and 2
      for (k = 0; k < 3; k++)
      begin
         mSize = k;
         wr(ufic_pkg::HOST_COMMAND_REG_OFS, 32'(k << 2));
         mIdx = $random(seed) & 32'h3fff;
         wr(ufic_pkg::MICROFRAME_INDEX_OFS, 32'(mIdx));
         chkAll();
      end
      // Microframe timing while running
      mSize = 0;
      wr(ufic_pkg::HOST_COMMAND_REG_OFS, 32'h1);
      mRun = 1;
      waitTick(n);
      chk("firstTick", 32'h1, 32'(n >= 6245 && n <= 6255));
      waitTick(n);
      chk("period", 32'd6250, 32'(n));
      // Low enable must hold the timer and swallow this stop command
      clkEn = 1'b0;
      wr(ufic_pkg::HOST_COMMAND_REG_OFS, 32'h0);
      k = 8 + ($random(seed) & 63);
      repeat (k) @(negedge clk);
      clkEn = 1'b1;
      waitTick(n);
      chk("frozenPeriod", 32'd6250, 32'(n));
      mIdx = (mIdx + 3) & 32'h3fff;
      wr(ufic_pkg::HOST_COMMAND_REG_OFS, 32'h0);
      mRun = 0;
      repeat (7000) @(negedge clk);
      chkAll();
      // Rollover of the whole counter and of the list
      mSize = 2;
      wr(ufic_pkg::HOST_COMMAND_REG_OFS, 32'h8);
      wr(ufic_pkg::MICROFRAME_INDEX_OFS, 32'h3fff);
      wr(ufic_pkg::HOST_COMMAND_REG_OFS, 32'h9);
      waitTick(n);
      wr(ufic_pkg::HOST_COMMAND_REG_OFS, 32'h8);
      mIdx = 0;
      chk("wrapFlag", 32'h1, {31'h0, listWrapFlag});
      rdChk("statusReg", ufic_pkg::HOST_STATUS_REG_OFS, 32'h8);
      chkAll();
      wr(ufic_pkg::HOST_STATUS_REG_OFS, 32'h8);
      chk("wrapClear", 32'h0, {31'h0, listWrapFlag});
      // Port routing and power gating
      portConnect = 1'($random(seed));
      wr(ufic_pkg::PORT_STATE_CTRL_REG_OFS, 32'h2004);
      chkAll();
      wr(ufic_pkg::PORT_STATE_CTRL_REG_OFS, 32'h1000);
      mPow = 1;
      // Ideal supply settles at once; a short wait keeps the run brief
      repeat (16) @(negedge clk);
      wr(ufic_pkg::PORT_STATE_CTRL_REG_OFS, 32'h3004);
      mEn = int'(portConnect);
      chkAll();
      wr(ufic_pkg::CONFIGURE_FLAG_REG_OFS, 32'h1);
      mCf = 1;
      mOwn = 0;
      chkAll();
      wr(ufic_pkg::PORT_STATE_CTRL_REG_OFS, 32'h3000);
      mOwn = 1;
      mEn = 0;
      chkAll();
      // Controller reset returns the port to its initial state
      @(negedge clk);
      hcReset = 1'b1;
      @(negedge clk);
      hcReset = 1'b0;
      mIdx = 0; mSize = 0; mRun = 0; mCf = 0; mOwn = 1; mPow = 0; mEn = 0;
      chkAll();
      endSim();
   end
endmodule
